// *** design/abt_trace_buffer.sv ***
// Trace buffer: records every completed transfer of the traced bus into a
// circular 64-entry store, keeps a time tag and emits bus statistics events.
// Assumes the traced bus runs on i_clk; only the debug bus enable pin and the reset are async.
// Overview of operation
// [RQ1] Each entry is 128 bits; every observed transfer writes one entry.
// [RQ2] Bits 127:96 hold the time tag at the moment of recording.
// [RQ3] Bit 95 is one when a breakpoint hit belongs to the transfer.
// [RQ4] Bits 94:64 hold irq 15..1, write, trans, size, burst, master, lock, resp.
// [RQ5] Bits 63:32 hold read or write data, bits 31:0 the address.
// [RQ6] The time tag is a 32-bit count advancing only while its timer runs.
// [RQ7] The timer also runs when any processor has its up-counter enabled.
// [RQ8] With freeze set, debug mode stops the timer; force-run keeps it going.
// [RQ9] Transfers during a freeze are recorded with the frozen tag.
// [RQ10] Tracer and readout are gated off while the debug bus pin disables them.
// [RQ11] Setting enable records each transfer into the 1 KiB store, circularly.
// [RQ12] The index holds the next location and increments after each record.
// [RQ13] Recording stops when software clears enable or a breakpoint is hit.
// [RQ14] A breakpoint hit raises an interrupt request.
// [RQ15] Stored entries are readable through a separate readout port.
// [RQ16] Statistics events pass the trace filters only when filter select is set.
// [RQ17] Idle, busy, nonseq and seq events follow the transfer type with ready high.
// [RQ18] Seq or nonseq with ready gives a size event plus a read or write event.
// [RQ19] A wait-state event is active while ready is low with an OKAY response.
// [RQ20] Retry and split events follow RETRY and SPLIT responses.
// [RQ21] An entry is written once, when the data phase completes with ready high.
`default_nettype none
module abt_trace_buffer (
    input  wire logic        i_clk,                // System clock.
    input  wire logic        i_reset_n,            // Async reset, active low.
    input  wire logic        i_debug_bus_enable_pin, // Debug bus enable pin, async.
    input  wire logic        i_en_wr,              // Pulse: write trace enable.
    input  wire logic        i_en_wdata,           // Value for trace enable.
    input  wire logic        i_idx_wr,             // Pulse: write index.
    input  wire logic [5:0]  i_idx_wdata,          // Value for index.
    input  wire logic        i_debug_freeze_timer, // Freeze tag in debug mode.
    input  wire logic        i_timer_force_run,    // Keep tag running despite freeze.
    input  wire logic        i_timer_enable,       // Debug timer enabled.
    input  wire logic [3:0]  i_upcount_en,         // Per-processor up-counter on.
    input  wire logic        i_cpu_debug_mode,     // Processors in debug mode.
    input  wire logic        i_stat_filter_select, // Route events through filters.
    input  wire logic        i_stat_filter_pass,   // Filter verdict, current beat.
    input  wire logic        i_brk_hit,            // Breakpoint on address phase.
    input  wire logic [31:0] i_haddr,              // Traced bus address.
    input  wire logic [1:0]  i_htrans,             // Traced bus transfer type.
    input  wire logic        i_hwrite,             // Traced bus direction.
    input  wire logic [2:0]  i_hsize,              // Traced bus size.
    input  wire logic [2:0]  i_hburst,             // Traced bus burst.
    input  wire logic [3:0]  i_hmaster,            // Traced bus master number.
    input  wire logic        i_hmastlock,          // Traced bus lock.
    input  wire logic [31:0] i_hwdata,             // Traced bus write data.
    input  wire logic [31:0] i_hrdata,             // Traced bus read data.
    input  wire logic [1:0]  i_hresp,              // Traced bus response.
    input  wire logic        i_hready,             // Traced bus ready.
    input  wire logic [15:1] i_hirq,               // Interrupt lines.
    input  wire logic        i_rd_valid,           // Readout request valid.
    input  wire logic [5:0]  i_rd_index,           // Readout entry number.
    input  wire logic [1:0]  i_rd_word,            // Word 0 = bits 127:96.
    output logic             o_rd_ready,           // Readout request taken.
    output logic             o_rd_data_valid,      // Readout word valid.
    output logic [31:0]      o_rd_data,            // Readout word.
    input  wire logic        i_rd_data_ready,      // Receiver takes the word.
    output logic             o_trace_enable,       // Trace enable state.
    output logic [5:0]       o_index,              // Next entry location.
    output logic [31:0]      o_time_tag,           // Current time tag.
    output logic             o_brk_irq,            // One-cycle breakpoint interrupt.
    output logic             o_ev_idle,            // Statistics: idle.
    output logic             o_ev_busy,            // Statistics: busy.
    output logic             o_ev_nseq,            // Statistics: nonsequential.
    output logic             o_ev_seq,             // Statistics: sequential.
    output logic             o_ev_read,            // Statistics: read.
    output logic             o_ev_write,           // Statistics: write.
    output logic             o_ev_size,            // Statistics: transfer size.
    output logic             o_ev_wait,            // Statistics: wait state.
    output logic             o_ev_retry,           // Statistics: retry.
    output logic             o_ev_split            // Statistics: split.
);
    logic [127:0] store_q [abt_pkg::DEPTH];
    logic        sync1_q, bus_en_q;
    logic        en_q;
    logic [5:0]  idx_q;
    logic [31:0] tag_q;
    logic        ap_valid_q, ap_write_q, ap_lock_q, ap_brk_q;
    logic [1:0]  ap_trans_q;
    logic [2:0]  ap_size_q, ap_burst_q;
    logic [3:0]  ap_master_q;
    logic [31:0] ap_addr_q;
    logic        record, tag_run, xfer_beat, stat_ok, irq_q;
    logic [127:0] entry;
    logic [31:0] buf_q [abt_pkg::BUF_DEPTH];
    logic        wptr_q, rptr_q;
    logic [1:0]  cnt_q;
    logic        push, pop;
    logic [31:0] rd_word;

    // Two-flop synchroniser for the debug bus enable pin.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_q  <= 1'b0;
            bus_en_q <= 1'b0;
        end else begin
            sync1_q  <= i_debug_bus_enable_pin;
            bus_en_q <= sync1_q;
        end
    end

    // A transfer is recorded when its data phase ends with ready high.
    assign record = ap_valid_q && i_hready && en_q && bus_en_q; // RQ21 RQ10

    // Time tag runs from the debug timer or any up-counter unless frozen.
    assign tag_run = (i_timer_enable || (|i_upcount_en)) // RQ6 RQ7
                     && !(i_debug_freeze_timer && i_cpu_debug_mode
                          && !i_timer_force_run); // RQ8
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tag_q <= abt_pkg::TAG_RST;
        end else if (tag_run) begin
            tag_q <= tag_q + 32'h0000_0001; // RQ6
        end
    end

    // Enable: software writes it; a recorded breakpoint clears it. The
    // breakpoint wins a tie so that a halt cannot be undone by a stale write.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            en_q <= 1'b0;
        end else if (record && ap_brk_q) begin
            en_q <= 1'b0; // RQ13
        end else if (i_en_wr) begin
            en_q <= i_en_wdata; // RQ11 RQ13
        end
    end

    // Index advances after each record and wraps through the 64 entries.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            idx_q <= abt_pkg::IDX_RST;
        end else if (record) begin
            idx_q <= idx_q + 6'h01; // RQ12 RQ11
        end else if (i_idx_wr) begin
            idx_q <= i_idx_wdata;
        end
    end

    // Address phase latch: control signals are only valid in that phase.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ap_valid_q  <= 1'b0;
            ap_write_q  <= 1'b0;
            ap_lock_q   <= 1'b0;
            ap_brk_q    <= 1'b0;
            ap_trans_q  <= abt_pkg::TRANS_IDLE;
            ap_size_q   <= 3'h0;
            ap_burst_q  <= 3'h0;
            ap_master_q <= 4'h0;
            ap_addr_q   <= 32'h0000_0000;
        end else if (i_hready) begin
            ap_valid_q  <= i_htrans[1]; // RQ1
            ap_write_q  <= i_hwrite;
            ap_lock_q   <= i_hmastlock;
            ap_brk_q    <= i_brk_hit;
            ap_trans_q  <= i_htrans;
            ap_size_q   <= i_hsize;
            ap_burst_q  <= i_hburst;
            ap_master_q <= i_hmaster;
            ap_addr_q   <= i_haddr;
        end
    end

    // Entry assembly; the tag is whatever value stands now, frozen or not.
    always_comb begin
        entry = '0;
        entry[abt_pkg::TAG_HI:abt_pkg::TAG_LO] = tag_q; // RQ2 RQ9
        entry[abt_pkg::BRK_BIT]                = ap_brk_q; // RQ3
        entry[abt_pkg::IRQ_HI:abt_pkg::IRQ_LO] = i_hirq; // RQ4
        entry[abt_pkg::WR_BIT]                 = ap_write_q;
        entry[abt_pkg::TRN_LO +: 2]            = ap_trans_q;
        entry[abt_pkg::SIZE_LO +: 3]           = ap_size_q;
        entry[abt_pkg::BURST_LO +: 3]          = ap_burst_q;
        entry[abt_pkg::MST_LO +: 4]            = ap_master_q;
        entry[abt_pkg::LOCK_BIT]               = ap_lock_q;
        entry[abt_pkg::RESP_LO +: 2]           = i_hresp;
        entry[abt_pkg::DATA_LO +: 32]          = ap_write_q ? i_hwdata : i_hrdata; // RQ5
        entry[abt_pkg::ADDR_LO +: 32]          = ap_addr_q;
    end

    // Store: plain flops without reset, since contents are data only.
    always_ff @(posedge i_clk) begin
        if (record) begin
            store_q[idx_q] <= entry; // RQ1 RQ11
        end
    end

    // Interrupt pulse raised on the same edge that stores the breakpoint entry.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= record && ap_brk_q; // RQ14
        end
    end

    // Statistics events, registered; gated by the filter only when selected.
    assign stat_ok   = bus_en_q && (!i_stat_filter_select || i_stat_filter_pass); // RQ16 RQ10
    assign xfer_beat = i_hready && i_htrans[1];
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ev_idle  <= 1'b0;
            o_ev_busy  <= 1'b0;
            o_ev_nseq  <= 1'b0;
            o_ev_seq   <= 1'b0;
            o_ev_read  <= 1'b0;
            o_ev_write <= 1'b0;
            o_ev_size  <= 1'b0;
            o_ev_wait  <= 1'b0;
            o_ev_retry <= 1'b0;
            o_ev_split <= 1'b0;
        end else begin
            o_ev_idle  <= stat_ok && i_hready && (i_htrans == abt_pkg::TRANS_IDLE); // RQ17
            o_ev_busy  <= stat_ok && i_hready && (i_htrans == abt_pkg::TRANS_BUSY);
            o_ev_nseq  <= stat_ok && i_hready && (i_htrans == abt_pkg::TRANS_NONSEQ);
            o_ev_seq   <= stat_ok && i_hready && (i_htrans == abt_pkg::TRANS_SEQ);
            o_ev_read  <= stat_ok && xfer_beat && !i_hwrite; // RQ18
            o_ev_write <= stat_ok && xfer_beat && i_hwrite;
            o_ev_size  <= stat_ok && xfer_beat;
            o_ev_wait  <= stat_ok && !i_hready && (i_hresp == abt_pkg::RESP_OKAY); // RQ19
            o_ev_retry <= stat_ok && i_hready && (i_hresp == abt_pkg::RESP_RETRY); // RQ20
            o_ev_split <= stat_ok && i_hready && (i_hresp == abt_pkg::RESP_SPLIT);
        end
    end

    // Readout: a two-entry buffer lets the receiver stall without loss;
    // requests are refused while it is full or the debug bus is off.
    assign o_rd_ready      = bus_en_q && (cnt_q != 2'h2); // RQ15 RQ10
    assign o_rd_data_valid = (cnt_q != 2'h0);
    assign push            = i_rd_valid && o_rd_ready;
    assign pop             = o_rd_data_valid && i_rd_data_ready;
    assign rd_word         = store_q[i_rd_index][(7'(3 - i_rd_word)) * 32 +: 32];
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
            cnt_q  <= 2'h0;
        end else begin
            wptr_q <= wptr_q ^ push;
            rptr_q <= rptr_q ^ pop;
            cnt_q  <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge i_clk) begin
        if (push) begin
            buf_q[wptr_q] <= rd_word; // RQ15
        end
    end
    assign o_rd_data = buf_q[rptr_q];

    assign o_trace_enable = en_q;
    assign o_index        = idx_q;
    assign o_time_tag     = tag_q;
    assign o_brk_irq      = irq_q;

    // Checks kept beside the logic they guard.
    sequence rec_brk_s;
        record && ap_brk_q;
    endsequence
    sequence halt_s;
        !en_q && o_brk_irq;
    endsequence
    idx_step_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ12
        record |=> idx_q == $past(idx_q) + 6'h01)
        else $error("Index did not advance after a record.");
    brk_halt_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ13
        rec_brk_s |=> halt_s ##1 !o_brk_irq)
        else $error("Breakpoint did not stop tracing.");
    brk_irq_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ14
        o_brk_irq |-> $past(record) && $past(ap_brk_q))
        else $error("Interrupt without a recorded breakpoint.");
    tag_freeze_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ8
        (i_debug_freeze_timer && i_cpu_debug_mode && !i_timer_force_run)
        |=> $stable(tag_q))
        else $error("Time tag moved while frozen.");
    tag_run_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ7
        (|i_upcount_en && !i_debug_freeze_timer) |=> tag_q == $past(tag_q) + 32'h0000_0001)
        else $error("Time tag failed to advance.");
    tag_entry_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ2
        record |=> store_q[$past(idx_q)][127:96] == $past(tag_q))
        else $error("Stored time tag differs from counter.");
    gate_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ10
        !bus_en_q |-> !o_rd_ready && !record)
        else $error("Tracer active while debug bus is off.");
    wait_ev_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ19
        (stat_ok && !i_hready && i_hresp == abt_pkg::RESP_OKAY) |=> o_ev_wait)
        else $error("Wait-state event missing.");
    read_ev_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ18
        o_ev_read |-> $past(i_hready) && $past(i_htrans[1]) && !$past(i_hwrite) && o_ev_size)
        else $error("Read event without a read beat.");
    buf_keep_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RQ15
        (o_rd_data_valid && !i_rd_data_ready) |=> o_rd_data_valid && $stable(o_rd_data))
        else $error("Readout word lost under stall.");
endmodule
`default_nettype wire

// *** design/abt_pkg.sv ***
// Package for the bus trace buffer: entry layout, bus encodings and store sizes.
// Assumes the traced bus and the tracer share one 250 MHz system clock.
`default_nettype none
package abt_pkg;
    // Clock period in picoseconds, kept for anyone deriving times from cycles.
    localparam int unsigned CLK_PERIOD_PS = 4000;
    // Store of 1 KiB holding 16-byte entries.
    localparam int unsigned STORE_BYTES   = 1024;
    localparam int unsigned ENTRY_W       = 128;
    localparam int unsigned DEPTH         = STORE_BYTES / (ENTRY_W / 8);
    localparam int unsigned IDX_W         = $clog2(DEPTH);
    // Entry field positions.
    localparam int unsigned TAG_HI   = 127;
    localparam int unsigned TAG_LO   = 96;
    localparam int unsigned BRK_BIT  = 95;
    localparam int unsigned IRQ_HI   = 94;
    localparam int unsigned IRQ_LO   = 80;
    localparam int unsigned WR_BIT   = 79;
    localparam int unsigned TRN_LO   = 77;
    localparam int unsigned SIZE_LO  = 74;
    localparam int unsigned BURST_LO = 71;
    localparam int unsigned MST_LO   = 67;
    localparam int unsigned LOCK_BIT = 66;
    localparam int unsigned RESP_LO  = 64;
    localparam int unsigned DATA_LO  = 32;
    localparam int unsigned ADDR_LO  = 0;
    // Transfer types and responses of the traced bus.
    localparam logic [1:0] TRANS_IDLE   = 2'h0;
    localparam logic [1:0] TRANS_BUSY   = 2'h1;
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TRANS_SEQ    = 2'h3;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_RETRY   = 2'h2;
    localparam logic [1:0] RESP_SPLIT   = 2'h3;
    // Reset values.
    localparam logic [31:0] TAG_RST     = 32'h0000_0000;
    localparam logic [5:0]  IDX_RST     = 6'h00;
    // Two-entry readout buffer.
    localparam int unsigned BUF_DEPTH   = 2;
endpackage
`default_nettype wire

// *** test/abt_bus_partner.sv ***
// Behavioural model of the traced bus: masters issue transfers, slaves answer them.
// Assumes one clock shared with the tracer and an active-low asynchronous reset.
`default_nettype none
module abt_bus_partner (
    input  wire logic        i_clk,       // System clock.
    input  wire logic        i_reset_n,   // Async reset, active low.
    output logic [31:0]      o_haddr,     // Address.
    output logic [1:0]       o_htrans,    // Transfer type.
    output logic             o_hwrite,    // Direction.
    output logic [2:0]       o_hsize,     // Size.
    output logic [2:0]       o_hburst,    // Burst.
    output logic [3:0]       o_hmaster,   // Master number.
    output logic             o_hmastlock, // Lock.
    output logic [31:0]      o_hwdata,    // Write data.
    output logic [31:0]      o_hrdata,    // Read data, noise until ready.
    output logic [1:0]       o_hresp,     // Response.
    output logic             o_hready,    // Ready.
    output logic [15:1]      o_hirq       // Interrupt lines.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic err_q; // First cycle of a two-cycle retry or split response.

    // The address phase moves only on ready; read data changes every cycle so that
    // a tracer sampling it at the wrong moment sees a different word.
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {o_haddr, o_htrans, o_hwrite, o_hsize, o_hburst, o_hmaster} <= '0;
            {o_hmastlock, o_hwdata, o_hrdata, o_hresp, o_hirq, err_q} <= '0;
            o_hready <= 1'b1;
        end else begin
            o_hrdata <= $urandom;
            o_hirq <= 15'($urandom);
            if (err_q) begin
                o_hready <= 1'b1;
                err_q <= 1'b0;
            end else if (o_hready) begin
                {o_haddr, o_htrans, o_hwrite, o_hsize, o_hburst, o_hmaster,
                 o_hmastlock} <= {$urandom, 14'($urandom)};
                o_hwdata <= $urandom;
                if (o_htrans[1] && $urandom % 8 == 0) begin
                    o_hresp <= 2'($urandom % 2 + 2);
                    o_hready <= 1'b0;
                    err_q <= 1'b1;
                end else begin
                    o_hresp <= 2'h0;
                    o_hready <= ($urandom % 4 != 0);
                end
            end else begin
                o_hready <= ($urandom % 2 != 0);
            end
        end
    end
endmodule
`default_nettype wire

// *** test/abt_trace_buffer_tb.sv ***
// Self-checking bench for the trace buffer, with a reference model kept in logic vectors.
// Assumes the bus partner model drives the traced bus on the same clock.
`default_nettype none
module abt_trace_buffer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         i_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         pin = 1'b1;
    logic         fpass = 1'b0;
    logic         dready = 1'b0;
    logic         en_wr, en_wd, idx_wr, fz, frc, ten, dbg, fsel, brk, rd_v;
    logic [5:0]   idx_wd, rd_i, index, m_idx;
    logic [3:0]   upc, hmaster;
    logic [1:0]   rd_w, htrans, hresp;
    logic [31:0]  haddr, hwdata, hrdata, rd_data, tag, m_tag, ph_a;
    logic [31:0]  rdq [$];
    logic [2:0]   hsize, hburst;
    logic [15:1]  hirq;
    logic         hwrite, hlock, hready, rd_rdy, rd_dv, t_en, irq;
    logic         m_en, m_irq, s1, s2, ph_v, rec;
    logic [9:0]   ev, m_ev;
    logic [14:0]  ph_c;
    logic [127:0] store [64];
    bit           wr_ok [64];
    int           fail_count = 0;
    int           check_count = 0;

    abt_bus_partner abt_bus_partner_inst (.i_clk(i_clk), .i_reset_n(rst_n),
        .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hburst(hburst), .o_hmaster(hmaster), .o_hmastlock(hlock), .o_hwdata(hwdata),
        .o_hrdata(hrdata), .o_hresp(hresp), .o_hready(hready), .o_hirq(hirq));

    abt_trace_buffer abt_trace_buffer_inst (.i_clk(i_clk), .i_reset_n(rst_n),
        .i_debug_bus_enable_pin(pin), .i_en_wr(en_wr), .i_en_wdata(en_wd),
        .i_idx_wr(idx_wr), .i_idx_wdata(idx_wd), .i_debug_freeze_timer(fz),
        .i_timer_force_run(frc), .i_timer_enable(ten), .i_upcount_en(upc),
        .i_cpu_debug_mode(dbg), .i_stat_filter_select(fsel), .i_stat_filter_pass(fpass),
        .i_brk_hit(brk), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hburst(hburst), .i_hmaster(hmaster), .i_hmastlock(hlock),
        .i_hwdata(hwdata), .i_hrdata(hrdata), .i_hresp(hresp), .i_hready(hready),
        .i_hirq(hirq), .i_rd_valid(rd_v), .i_rd_index(rd_i), .i_rd_word(rd_w),
        .o_rd_ready(rd_rdy), .o_rd_data_valid(rd_dv), .o_rd_data(rd_data),
        .i_rd_data_ready(dready), .o_trace_enable(t_en), .o_index(index),
        .o_time_tag(tag), .o_brk_irq(irq), .o_ev_idle(ev[9]), .o_ev_busy(ev[8]),
        .o_ev_nseq(ev[7]), .o_ev_seq(ev[6]), .o_ev_read(ev[5]), .o_ev_write(ev[4]),
        .o_ev_size(ev[3]), .o_ev_wait(ev[2]), .o_ev_retry(ev[1]), .o_ev_split(ev[0]));

    // The clock toggles every half period of 2 ns.
    always #2 i_clk = ~i_clk;

    // Filter verdict and receiver stalls change every cycle to exercise the buffer.
    always @(posedge i_clk) {fpass, dready} <= 2'($urandom);

    task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Reference model: outputs are compared with the values it settled one edge earlier.
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            {m_tag, m_idx, m_en, m_irq, s1, s2, m_ev, ph_v} = '0;
        end else begin
            chk("time tag", tag, m_tag);
            chk("index", index, m_idx);
            chk("trace enable", t_en, m_en);
            chk("breakpoint irq", irq, m_irq);
            chk("events", ev, m_ev);
            if (rd_dv && dready) chk("readout", rd_data, rdq.pop_front());
            m_ev = '0;
            if (s2 && (!fsel || fpass)) begin
                m_ev[9 - int'(htrans)] = hready;
                m_ev[5:3] = {3{hready && htrans[1]}} & {!hwrite, hwrite, 1'b1};
                m_ev[2] = !hready && hresp == abt_pkg::RESP_OKAY;
                m_ev[1] = hready && hresp == abt_pkg::RESP_RETRY;
                m_ev[0] = hready && hresp == abt_pkg::RESP_SPLIT;
            end
            m_irq = 1'b0;
            rec = hready && ph_v && m_en && s2;
            if (en_wr) m_en = en_wd;
            if (rec) begin
                store[m_idx] = {m_tag, ph_c[14], hirq, ph_c[13:0], hresp,
                                ph_c[13] ? hwdata : hrdata, ph_a};
                wr_ok[m_idx] = 1'b1;
                m_idx++;
                if (ph_c[14]) {m_en, m_irq} = 2'b01;
            end else if (idx_wr) begin
                m_idx = idx_wd;
            end
            if (hready) {ph_v, ph_c, ph_a} = {htrans[1], brk, hwrite, htrans, hsize,
                                              hburst, hmaster, hlock, haddr};
            if ((ten || |upc) && !(fz && dbg && !frc)) m_tag++;
            s2 = s1;
            s1 = pin;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic en(input logic v);
        en_wr <= 1'b1;
        en_wd <= v;
        cyc(1);
        en_wr <= 1'b0;
    endtask

    // Every stored word goes through the readout port; data is judged by the model.
    task automatic read_all(input string name);
        for (int i = 0; i < 64; i++) for (int w = 0; w < 4; w++) if (wr_ok[i]) begin
            rd_v <= 1'b1;
            rd_i <= 6'(i);
            rd_w <= 2'(w);
            do @(posedge i_clk); while (rd_rdy !== 1'b1);
            rdq.push_back(store[i][127 - 32 * w -: 32]);
        end
        rd_v <= 1'b0;
        cyc(8);
        $display("test %s done", name);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog sized well above the expected few thousand cycles.
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end

    // Timer modes, index wrap, breakpoint stop and debug bus gating in turn.
    initial begin
        void'($urandom(71));
        {en_wr, en_wd, idx_wr, idx_wd, fz, frc, ten, dbg, fsel, brk, upc} = '0;
        {rd_v, rd_i, rd_w} = '0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(3);
        en(1'b1);
        for (int p = 0; p < 24; p++) begin
            {ten, upc, fz, frc, dbg, fsel} <= 9'($urandom);
            cyc(20);
        end
        en(1'b0);
        read_all("timer and trace");
        idx_wr <= 1'b1;
        idx_wd <= 6'h3e;
        cyc(1);
        idx_wr <= 1'b0;
        en(1'b1);
        cyc(12);
        en(1'b0);
        read_all("index wrap");
        en(1'b1);
        brk <= 1'b1;
        // Wait on the settled enable output so that the breakpoint is seen at least once.
        cyc(2);
        for (int k = 0; k < 60 && t_en === 1'b1; k++) cyc(1);
        brk <= 1'b0;
        cyc(20);
        chk("stopped by breakpoint", t_en, 1'b0);
        read_all("breakpoint");
        en(1'b1);
        pin <= 1'b0;
        cyc(30);
        pin <= 1'b1;
        cyc(5);
        en(1'b0);
        read_all("bus gating");
        chk("readout drained", rdq.size(), 0);
        complete_run();
    end
endmodule
`default_nettype wire
